// File: design/prtc_defs.vh
// register map, field layout, reset values and timing counts for the ptp rtc
`ifndef PRTC_DEFS_VH
`define PRTC_DEFS_VH
`define PRTC_OFF_STAT      8'h04
`define PRTC_OFF_RX_LOW    8'h1C
`define PRTC_OFF_RX_HIGH   8'h20
`define PRTC_OFF_SEQ_PORT  8'h24
`define PRTC_OFF_SRC_HIGH  8'h28
`define PRTC_OFF_SRC_LOW   8'h2C
`define PRTC_OFF_NS        8'h30
`define PRTC_OFF_SEC       8'h34
`define PRTC_OFF_TRIM      8'h38
`define PRTC_STAT_RX_BIT   1
`define PRTC_STEP_HI       31
`define PRTC_STEP_LO       27
`define PRTC_EN_BIT        26
`define PRTC_MAX_HI        23
`define PRTC_MAX_LO        0
`define PRTC_TRIM_MASK     32'hFCFFFFFF
`define PRTC_TRIM_RESET    32'hA0000000
`define PRTC_ZERO32        32'h00000000
`define PRTC_NORMAL_STEP   32'h00000014
`define PRTC_NS_PER_SEC    32'h3B9ACA00
`define PRTC_REF_CLK_MHZ   50
`define PRTC_RESP_OKAY     2'h0
`define PRTC_RESP_SLVERR   2'h2
`endif

// File: design/prtc_sync2.v
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module prtc_sync2 (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // level in and out
    input wire d,
    output reg q
);
    reg meta_reg;
    // meta_reg feeds q only; nothing else may look at it
    always @(posedge clk) begin
        if (!reset_n) begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // prtc_sync2

// File: design/prtc_clock_core.v
// nanoseconds and seconds counters with periodic rate trim
`timescale 1ns/1ps
`include "prtc_defs.vh"
module prtc_clock_core (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // trim settings
    input wire [4:0] trim_step,
    input wire trim_enable,
    input wire [23:0] trim_period_max,
    // load port
    input wire load,
    input wire [31:0] load_ns,
    input wire [31:0] load_sec,
    // running time
    output reg [31:0] ns_reg,
    output reg [31:0] sec_reg
);
    reg [23:0] adj_cnt_reg;
    wire adj_wrap;
    wire [32:0] ns_sum;
    wire [31:0] incr;
    // counter returns to zero on reaching the maximum
    assign adj_wrap = (adj_cnt_reg == trim_period_max);
    // trim step replaces the normal 20 in the wrap cycle
    assign incr = (adj_wrap && trim_enable) ? {27'h0, trim_step}
                  : `PRTC_NORMAL_STEP;
    assign ns_sum = {1'b0, ns_reg} + {1'b0, incr};
    // adjustment counter is free running, even while disabled
    always @(posedge clk) begin
        if (!reset_n)
            adj_cnt_reg <= 24'h000000;
        else if (adj_wrap)
            adj_cnt_reg <= 24'h000000;
        else
            adj_cnt_reg <= adj_cnt_reg + 24'h000001;
    end
    // time update; a software load wins over the tick
    always @(posedge clk) begin
        if (!reset_n) begin
            ns_reg <= `PRTC_ZERO32;
            sec_reg <= `PRTC_ZERO32;
        end else if (load) begin
            ns_reg <= load_ns;
            sec_reg <= load_sec;
        end else if (ns_sum >= {1'b0, `PRTC_NS_PER_SEC}) begin
            ns_reg <= ns_sum[31:0] - `PRTC_NS_PER_SEC;
            sec_reg <= sec_reg + 32'h00000001;
        end else begin
            ns_reg <= ns_sum[31:0];
        end
    end
endmodule // prtc_clock_core

// File: design/prtc_top.v
// ptp real-time clock with rate trim and receive timestamp identity regs
`timescale 1ns/1ps
`include "prtc_defs.vh"
module prtc_top (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // frame detector side (same clock)
    input wire rx_frame_seen,
    input wire [15:0] rx_sequence_number,
    input wire [15:0] rx_source_port_number,
    input wire [63:0] rx_source_identity,
    // status pin
    output reg rx_stamp_event_flag
);
    // captured receive data
    reg [31:0] rx_stamp_low_reg;
    reg [31:0] rx_stamp_high_reg;
    reg [31:0] rx_stamp_seq_port_reg;
    reg [31:0] rx_source_id_high_reg;
    reg [31:0] rx_source_id_low_reg;
    reg rx_flag_reg;
    // software side of the clock
    reg [31:0] rate_trim_reg;
    reg [31:0] ns_hold_reg;
    reg [31:0] sec_snap_reg;
    reg load_reg;
    reg [31:0] load_sec_reg;
    // write channel latches
    reg aw_have_reg;
    reg w_have_reg;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    // clock core outputs and bus decode nets
    wire [31:0] ns_now;
    wire [31:0] sec_now;
    wire [31:0] wmask;
    wire [31:0] wr_val;
    wire do_write;
    wire do_read;
    wire flag_clear;
    // reset after the two-flop release stage
    wire reset_sync_n;
    // decode results, built combinationally
    reg [31:0] rd_val;
    reg rd_ok;
    reg wr_ok;

    // reset release from the pin passes two flops first, so a release
    // close to an edge cannot free some registers a cycle before others
    prtc_sync2 u_reset_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d(1'b1),
        .q(reset_sync_n)
    );

    // trim fields feed the core straight from the register
    prtc_clock_core u_core (
        .clk(clk),
        .reset_n(reset_sync_n),
        .trim_step(rate_trim_reg[`PRTC_STEP_HI:`PRTC_STEP_LO]),
        .trim_enable(rate_trim_reg[`PRTC_EN_BIT]),
        .trim_period_max(rate_trim_reg[`PRTC_MAX_HI:`PRTC_MAX_LO]),
        .load(load_reg),
        .load_ns(ns_hold_reg),
        .load_sec(load_sec_reg),
        .ns_reg(ns_now),
        .sec_reg(sec_now)
    );

    // byte-lane mask from the write strobes
    assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                    {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    // write happens once both address and data are latched
    assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
    // a read is taken on the address handshake itself
    assign do_read = s_axi_arvalid && s_axi_arready;
    // write one to the status bit clears the receive flag
    assign flag_clear = do_write && (aw_addr_reg == `PRTC_OFF_STAT) &&
                        wmask[`PRTC_STAT_RX_BIT] &&
                        w_data_reg[`PRTC_STAT_RX_BIT];

    // merged value of a register under the byte strobes
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [31:0] m;
        begin
            merge = (old_v & ~m) | (new_v & m);
        end
    endfunction
    // write data is used as latched, merged per register below
    assign wr_val = w_data_reg;

    // address decode for writes; read-only words accept and ignore
    // the address was already rounded down to its word
    always @* begin
        case (aw_addr_reg)
            `PRTC_OFF_STAT, `PRTC_OFF_RX_LOW, `PRTC_OFF_RX_HIGH,
            `PRTC_OFF_SEQ_PORT, `PRTC_OFF_SRC_HIGH, `PRTC_OFF_SRC_LOW,
            `PRTC_OFF_NS, `PRTC_OFF_SEC, `PRTC_OFF_TRIM: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // read mux; unmapped addresses answer slverr with zero data
    // the seconds word reads the snapshot, not the live count
    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `PRTC_OFF_STAT: rd_val = {30'h0, rx_flag_reg, 1'b0};
            `PRTC_OFF_RX_LOW: rd_val = rx_stamp_low_reg;
            `PRTC_OFF_RX_HIGH: rd_val = rx_stamp_high_reg;
            `PRTC_OFF_SEQ_PORT: rd_val = rx_stamp_seq_port_reg;
            `PRTC_OFF_SRC_HIGH: rd_val = rx_source_id_high_reg;
            `PRTC_OFF_SRC_LOW: rd_val = rx_source_id_low_reg;
            `PRTC_OFF_NS: rd_val = ns_now;
            `PRTC_OFF_SEC: rd_val = sec_snap_reg;
            `PRTC_OFF_TRIM: rd_val = rate_trim_reg;
            default: begin
                rd_val = `PRTC_ZERO32;
                rd_ok = 1'b0;
            end
        endcase
    end

    // write address and data channels, taken in either order
    always @(posedge clk) begin
        if (!reset_sync_n) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= `PRTC_ZERO32;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PRTC_RESP_OKAY;
        end else begin
            // each ready pulses every second cycle until taken, then stays low until the response is accepted
            s_axi_awready <= !aw_have_reg && !s_axi_awready &&
                             !s_axi_bvalid;
            s_axi_wready <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // the response follows once both halves are in
            if (do_write) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `PRTC_RESP_OKAY : `PRTC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one cycle from address to data
    always @(posedge clk) begin
        if (!reset_sync_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `PRTC_ZERO32;
            s_axi_rresp <= `PRTC_RESP_OKAY;
        end else begin
            // arready stays low while read data waits to be taken
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? `PRTC_RESP_OKAY : `PRTC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // seconds snapshot taken whenever the nanoseconds word is read,
    // so an ns-then-seconds pair cannot straddle a rollover
    always @(posedge clk) begin
        if (!reset_sync_n)
            sec_snap_reg <= `PRTC_ZERO32;
        else if (do_read && s_axi_araddr == `PRTC_OFF_NS)
            sec_snap_reg <= sec_now;
    end

    // software writes to trim and the two-word time load; a
    // nanoseconds write only parks its value, the seconds write then
    // loads both so the pair lands on one edge
    always @(posedge clk) begin
        if (!reset_sync_n) begin
            rate_trim_reg <= `PRTC_TRIM_RESET;
            ns_hold_reg <= `PRTC_ZERO32;
            load_sec_reg <= `PRTC_ZERO32;
            load_reg <= 1'b0;
        end else begin
            load_reg <= 1'b0;
            if (do_write) begin
                case (aw_addr_reg)
                    `PRTC_OFF_TRIM:
                        // reserved bits 25:24 never hold a one
                        rate_trim_reg <= merge(rate_trim_reg, wr_val,
                                               wmask) & `PRTC_TRIM_MASK;
                    `PRTC_OFF_NS:
                        ns_hold_reg <= merge(ns_hold_reg, wr_val,
                                             wmask);
                    `PRTC_OFF_SEC: begin
                        load_sec_reg <= merge(sec_now, wr_val, wmask);
                        load_reg <= 1'b1;
                    end
                    default: load_reg <= 1'b0;
                endcase
            end
        end
    end

    // capture on frame receipt; held while the flag is still set,
    // and a new frame wins over a clear in the same cycle; the stamp
    // is the time that stands at the pulse edge
    always @(posedge clk) begin
        if (!reset_sync_n) begin
            rx_stamp_low_reg <= `PRTC_ZERO32;
            rx_stamp_high_reg <= `PRTC_ZERO32;
            rx_stamp_seq_port_reg <= `PRTC_ZERO32;
            rx_source_id_high_reg <= `PRTC_ZERO32;
            rx_source_id_low_reg <= `PRTC_ZERO32;
            rx_flag_reg <= 1'b0;
            rx_stamp_event_flag <= 1'b0;
        end else begin
            if (rx_frame_seen && (!rx_flag_reg || flag_clear)) begin
                rx_stamp_low_reg <= ns_now;
                rx_stamp_high_reg <= sec_now;
                rx_stamp_seq_port_reg <= {rx_sequence_number,
                                          rx_source_port_number};
                rx_source_id_high_reg <= rx_source_identity[63:32];
                rx_source_id_low_reg <= rx_source_identity[31:0];
                rx_flag_reg <= 1'b1;
                rx_stamp_event_flag <= 1'b1;
            end else if (flag_clear) begin
                rx_flag_reg <= 1'b0;
                rx_stamp_event_flag <= 1'b0;
            end
        end
    end
endmodule // prtc_top

// File: tb/prtc_top_sva.sv
// bus handshake and receive flag assertions for prtc_top
`timescale 1ns/1ps
`include "prtc_defs.vh"
module prtc_top_sva (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // write channels
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // read channels
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // frame side
    input wire rx_frame_seen,
    input wire rx_stamp_event_flag
);
    default clocking @(posedge clk); endclocking
    // the design leaves reset two edges after the pin; wait that out
    reg [2:0] rel_reg = 3'h0;
    always @(posedge clk)
        rel_reg <= reset_n ? {rel_reg[1:0], 1'b1} : 3'h0;
    default disable iff (!reset_n || !rel_reg[2]);
    // read request taken this edge
    wire ar_take = s_axi_arvalid && s_axi_arready;
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("no write response");
    AST_R_ANS: assert property (ar_take |=> s_axi_rvalid)
        else $error("no read response");
    AST_BUSY: assert property ((s_axi_bvalid |-> !s_axi_awready &&
        !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready))
        else $error("ready while answer pending");
    AST_UNMAPPED: assert property (ar_take && s_axi_araddr > 8'h38 |=>
        s_axi_rresp == `PRTC_RESP_SLVERR && s_axi_rdata == `PRTC_ZERO32)
        else $error("unmapped read not refused");
    AST_TRIM_RSVD: assert property (ar_take &&
        s_axi_araddr == `PRTC_OFF_TRIM |=> s_axi_rdata[25:24] == 2'h0)
        else $error("reserved trim bits set");
    AST_FLAG_SET: assert property (rx_frame_seen |=>
        rx_stamp_event_flag) else $error("flag not set by frame");
    AST_FLAG_CAUSE: assert property ($rose(rx_stamp_event_flag) |->
        $past(rx_frame_seen)) else $error("flag rose without frame");
    // main scenarios reached
    cover property (ar_take ##1 s_axi_rvalid);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (rx_frame_seen && rx_stamp_event_flag);
endmodule // prtc_top_sva
bind prtc_top prtc_top_sva u_sva (.*);

// File: tb/ptp_rtc_rate_adjust_tb.sv
// self-checking bench for the ptp rtc over axi4-lite
`timescale 1ns/1ps
`include "prtc_defs.vh"
module ptp_rtc_rate_adjust_tb;
    logic clk = 0;
    logic reset_n = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, rx_frame_seen = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rx_stamp_event_flag;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] rx_sequence_number = 0, rx_source_port_number = 0;
    logic [63:0] rx_source_identity = 0;
    int n_mismatch = 0, checks_done = 0, cyc = 0, t_ar = 0;
    prtc_top u_dut (.*);
    initial forever #5 clk = ~clk;
    // cycle count used to time the read snapshots
    always @(posedge clk) cyc <= cyc + 1;
    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // offer address and data together, drop each once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        logic ad, dd;
        ad = 0;
        dd = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (s_axi_awready) ad = 1;
            if (s_axi_wready) dd = 1;
            if (ad) s_axi_awvalid <= 0;
            if (dd) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 1;
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
            input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        t_ar = cyc;
        s_axi_arvalid <= 0;
        s_axi_rready <= 1;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        s_axi_rready <= 0;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v, `PRTC_RESP_OKAY);
        chk(v, e);
    endtask
    // two ns reads; half means one 20 ns tick every second cycle
    task automatic meas(input int inc, input bit half);
        logic [31:0] v1, v2;
        int t1, d;
        rd(`PRTC_OFF_NS, v1, `PRTC_RESP_OKAY);
        t1 = t_ar;
        rd(`PRTC_OFF_NS, v2, `PRTC_RESP_OKAY);
        d = t_ar - t1;
        if (half && v2 - v1 == 32'(20 * ((d + 1) / 2)))
            v2 = v2 - 32'(20 * (d % 2));
        chk(v2 - v1, 32'(half ? 20 * (d / 2) : inc * d));
    endtask
    // sequence number and identity are inverted after the pulse so a live copy shows up
    task automatic fr(input logic [15:0] s, input logic [63:0] id);
        rx_sequence_number <= s;
        rx_source_port_number <= ~s;
        rx_source_identity <= id;
        rx_frame_seen <= 1;
        @(posedge clk);
        rx_frame_seen <= 0;
        rx_sequence_number <= ~s;
        rx_source_identity <= ~id;
        @(posedge clk);
        @(posedge clk);
    endtask
    task automatic t_reset_vals;
        rdc(`PRTC_OFF_RX_LOW, 0);
        rdc(`PRTC_OFF_RX_HIGH, 0);
        rdc(`PRTC_OFF_SEQ_PORT, 0);
        rdc(`PRTC_OFF_SRC_HIGH, 0);
        rdc(`PRTC_OFF_SRC_LOW, 0);
        rdc(`PRTC_OFF_SEC, 0);
        rdc(`PRTC_OFF_TRIM, `PRTC_TRIM_RESET);
    endtask
    task automatic t_refuse;
        logic [31:0] v;
        wr(`PRTC_OFF_SEQ_PORT, 32'hFFFFFFFF, `PRTC_RESP_OKAY);
        rdc(`PRTC_OFF_SEQ_PORT, 0);
        rd(8'h3C, v, `PRTC_RESP_SLVERR);
        chk(v, 0);
        wr(8'h3C, 32'h00000001, `PRTC_RESP_SLVERR);
    endtask
    task automatic t_trim;
        meas(20, 0);
        wr(`PRTC_OFF_TRIM, 32'h04000000, `PRTC_RESP_OKAY);
        meas(0, 0);
        wr(`PRTC_OFF_TRIM, 32'hFC000000, `PRTC_RESP_OKAY);
        meas(31, 0);
        wr(`PRTC_OFF_TRIM, 32'h04000001, `PRTC_RESP_OKAY);
        meas(0, 1);
        wr(`PRTC_OFF_TRIM, 32'hF8000000, `PRTC_RESP_OKAY);
        meas(20, 0);
        wr(`PRTC_OFF_TRIM, 32'hFFFFFFFF, `PRTC_RESP_OKAY);
        rdc(`PRTC_OFF_TRIM, `PRTC_TRIM_MASK);
        wr(`PRTC_OFF_TRIM, `PRTC_TRIM_RESET, `PRTC_RESP_OKAY);
    endtask
    // set just below a second boundary, then read the pair
    task automatic t_set;
        logic [31:0] v, s;
        wr(`PRTC_OFF_NS, 32'h3B9AC9EC, `PRTC_RESP_OKAY);
        rd(`PRTC_OFF_NS, v, `PRTC_RESP_OKAY);
        chk({31'h0, v < 32'h00100000}, 1);
        wr(`PRTC_OFF_SEC, 32'h00000005, `PRTC_RESP_OKAY);
        // the load lands one edge after the response, the rollover next
        @(posedge clk);
        rd(`PRTC_OFF_NS, v, `PRTC_RESP_OKAY);
        rdc(`PRTC_OFF_SEC, 32'h00000006);
        chk({31'h0, v < 32'd1000}, 1);
        chk(v % 20, 0);
    endtask
    task automatic t_frame;
        logic [31:0] v;
        fr(16'h1234, 64'h0123456789ABCDEF);
        chk({31'h0, rx_stamp_event_flag}, 1);
        rdc(`PRTC_OFF_SEQ_PORT, 32'h1234EDCB);
        rdc(`PRTC_OFF_SRC_HIGH, 32'h01234567);
        rdc(`PRTC_OFF_SRC_LOW, 32'h89ABCDEF);
        rdc(`PRTC_OFF_RX_HIGH, 32'h00000006);
        rd(`PRTC_OFF_RX_LOW, v, `PRTC_RESP_OKAY);
        chk(v % 20, 0);
        fr(16'h5555, 64'h0);
        rdc(`PRTC_OFF_SEQ_PORT, 32'h1234EDCB);
        wr(`PRTC_OFF_STAT, 32'h00000002, `PRTC_RESP_OKAY);
        chk({31'h0, rx_stamp_event_flag}, 0);
        fr(16'h00FF, 64'h0);
        rdc(`PRTC_OFF_SEQ_PORT, 32'h00FFFF00);
    endtask
    // watchdog: whole run needs a few hundred cycles
    initial begin
        #500000;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1;
        @(posedge clk);
        t_reset_vals();
        t_refuse();
        t_trim();
        t_set();
        t_frame();
        results();
    end
endmodule // ptp_rtc_rate_adjust_tb
